// >>> design/epla_cfg.svh
`ifndef EPLA_CFG_SVH
`define EPLA_CFG_SVH

// register byte offsets
`define EPLA_LINE_RESULT_ADR  8'h04
`define EPLA_OFFSET_ADR       8'h08
`define EPLA_NUMER_ADR        8'h0C
`define EPLA_DIVIS_ADR        8'h10
`define EPLA_MODE_ADR         8'h14
`define EPLA_STATUS_ADR       8'h18
`define EPLA_HALF_COUNT_ADR   8'h1C
`define EPLA_IRQ_EN_ADR       8'h20
`define EPLA_ENERGY_ADR       8'h24

// field positions
`define EPLA_LINE_MODE_BIT    7
`define EPLA_CYCLE_END_BIT    2

// reset values
`define EPLA_OFFSET_RST       16'h0000
`define EPLA_NUMER_RST        12'h000
`define EPLA_DIVIS_RST        12'h000
`define EPLA_HALF_COUNT_RST   16'h0000

// timing
`define EPLA_CLK_DIV          4
`define EPLA_FIXED_TICKS      16
`define EPLA_HOLD_MS          90
`define EPLA_LONG_MS          180
`define EPLA_CLK_KHZ          50000

`endif

// >>> design/epla_pkg.sv
package epla_pkg;

  typedef enum logic [2:0] {
    EPLA_IDLE  = 3'b001,
    EPLA_START = 3'b010,
    EPLA_ACCUM = 3'b100
  } epla_line_state_e;

  typedef logic signed [56:0] epla_acc_t;

endpackage

// >>> design/epla_energy_pulse.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "epla_cfg.svh"

module epla_energy_pulse
  import epla_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `EPLA_HOLD_MS * `EPLA_CLK_KHZ,
  parameter int unsigned LONG_CYCLES = `EPLA_LONG_MS * `EPLA_CLK_KHZ
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [23:0] power_sample_i,
  input  wire logic        zero_cross_i,
  output logic             calibration_pulse_out_o,
  output logic             irq_n_o,
  output logic             irq_oe_o
);

  localparam int unsigned FIXED_CYCLES = `EPLA_FIXED_TICKS * `EPLA_CLK_DIV;

  // register bus
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] offset_q;
  logic [11:0] numer_q;
  logic [11:0] divis_q;
  logic [7:0]  mode_q;
  logic [15:0] half_count_q;
  logic        irq_en_q;
  logic        cycle_end_q;
  logic [23:0] line_result_q;
  logic        bus_req;
  logic        wr_en;
  logic [31:0] wmask;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_en   = bus_req & wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_q     <= `EPLA_OFFSET_RST;
      numer_q      <= `EPLA_NUMER_RST;
      divis_q      <= `EPLA_DIVIS_RST;
      mode_q       <= 8'h00;
      half_count_q <= `EPLA_HALF_COUNT_RST;
      irq_en_q     <= 1'b0;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        `EPLA_OFFSET_ADR: begin
          offset_q <= 16'(merge({16'h0000, offset_q}, wb_dat_i, wmask));
        end
        `EPLA_NUMER_ADR: begin
          numer_q <= 12'(merge({20'h00000, numer_q}, wb_dat_i, wmask));
        end
        `EPLA_DIVIS_ADR: begin
          divis_q <= 12'(merge({20'h00000, divis_q}, wb_dat_i, wmask));
        end
        `EPLA_MODE_ADR: begin
          mode_q <= 8'(merge({24'h000000, mode_q}, wb_dat_i, wmask));
        end
        `EPLA_HALF_COUNT_ADR: begin
          half_count_q <= 16'(merge({16'h0000, half_count_q}, wb_dat_i, wmask));
        end
        `EPLA_IRQ_EN_ADR: begin
          if (wb_sel_i[0]) begin
            irq_en_q <= wb_dat_i[`EPLA_CYCLE_END_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // sample tick, clock divided by four
  logic [1:0] div_q;
  logic       tick;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign tick = (div_q == 2'h3);

  // offset correction and energy
  // low 8 bits are the 1/256 fraction of the offset; bits [56:8] form the 49-bit store
  epla_acc_t   corr;
  epla_acc_t   acc_q;
  logic [23:0] energy;
  logic [23:0] energy_prev_q;
  logic        dfc_q;

  assign corr   = {{25{power_sample_i[23]}}, power_sample_i, 8'h00}
                + {{41{offset_q[15]}}, offset_q};
  assign energy = acc_q[56:33];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_q + corr;
    end
  end

  // one sample moves the top 24 bits by at most one, so a change means one LSB
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      energy_prev_q <= 24'h000000;
      dfc_q         <= 1'b0;
    end else begin
      energy_prev_q <= energy;
      dfc_q         <= (energy != energy_prev_q);
    end
  end

  // frequency scaling
  logic [12:0] num_eff;
  logic [12:0] den_eff;
  logic [12:0] phase_q;
  logic [13:0] phase_sum;
  logic        emit_q;
  logic        clamp;

  assign num_eff   = (numer_q == 12'h000) ? 13'h0002 : {1'b0, numer_q} + 13'h0001;
  assign den_eff   = (divis_q == 12'h000) ? 13'h0002 : {1'b0, divis_q} + 13'h0001;
  assign clamp     = (num_eff >= den_eff);
  assign phase_sum = {1'b0, phase_q} + {1'b0, num_eff};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= 13'h0000;
      emit_q  <= 1'b0;
    end else begin
      emit_q <= 1'b0;
      if (dfc_q) begin
        if (clamp) begin
          phase_q <= 13'h0000;
          emit_q  <= 1'b1;
        end else if (phase_sum >= {1'b0, den_eff}) begin
          phase_q <= 13'(phase_sum - {1'b0, den_eff});
          emit_q  <= 1'b1;
        end else begin
          phase_q <= phase_sum[12:0];
        end
      end
    end
  end

  // output pulse width
  // width follows the previous output period, so the first pulse uses the saturated count
  logic [23:0] period_q;
  logic [23:0] width_q;
  logic [23:0] width_load;
  logic        fixed_width;

  assign fixed_width = (numer_q == 12'h001) && (divis_q == 12'h001);

  always_comb begin
    if (fixed_width) begin
      width_load = 24'(FIXED_CYCLES);
    end else if ({8'h00, period_q} > LONG_CYCLES) begin
      width_load = 24'(HOLD_CYCLES);
    end else if (period_q[23:1] == 23'h000000) begin
      width_load = 24'h000001;
    end else begin
      width_load = {1'b0, period_q[23:1]};
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_q <= 24'hFFFFFF;
    end else if (emit_q) begin
      period_q <= 24'h000001;
    end else if (period_q != 24'hFFFFFF) begin
      period_q <= period_q + 24'h000001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      width_q <= 24'h000000;
    end else if (emit_q) begin
      width_q <= width_load;
    end else if (width_q != 24'h000000) begin
      width_q <= width_q - 24'h000001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      calibration_pulse_out_o <= 1'b0;
    end else begin
      calibration_pulse_out_o <= emit_q | (width_q > 24'h000001);
    end
  end

  // line-cycle accumulation
  epla_line_state_e state_q;
  epla_acc_t        line_acc_q;
  epla_acc_t        line_next;
  logic [15:0]      half_cnt_q;
  logic [15:0]      half_target;
  logic             line_mode;
  logic             complete;

  assign line_mode   = mode_q[`EPLA_LINE_MODE_BIT];
  assign half_target = (half_count_q == 16'h0000) ? 16'h0001 : half_count_q;
  assign line_next   = tick ? line_acc_q + corr : line_acc_q;
  assign complete    = (state_q == EPLA_ACCUM) && line_mode && zero_cross_i
                     && (half_cnt_q + 16'h0001 == half_target);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q    <= EPLA_IDLE;
      line_acc_q <= '0;
      half_cnt_q <= 16'h0000;
    end else if (!line_mode) begin
      state_q <= EPLA_IDLE;
    end else begin
      unique case (state_q)
        EPLA_IDLE: begin
          state_q <= EPLA_START;
        end
        EPLA_START: begin
          if (zero_cross_i) begin
            state_q    <= EPLA_ACCUM;
            line_acc_q <= '0;
            half_cnt_q <= 16'h0000;
          end
        end
        EPLA_ACCUM: begin
          if (complete) begin
            line_acc_q <= '0;
            half_cnt_q <= 16'h0000;
          end else begin
            line_acc_q <= line_next;
            if (zero_cross_i) begin
              half_cnt_q <= half_cnt_q + 16'h0001;
            end
          end
        end
        default: begin
          state_q <= EPLA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_result_q <= 24'h000000;
    end else if (complete) begin
      line_result_q <= line_next[56:33];
    end
  end

  // hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cycle_end_q <= 1'b0;
    end else if (complete) begin
      cycle_end_q <= 1'b1;
    end else if (wr_en && wb_adr_i == `EPLA_STATUS_ADR && wb_sel_i[0]
                 && wb_dat_i[`EPLA_CYCLE_END_BIT]) begin
      cycle_end_q <= 1'b0;
    end
  end

  assign irq_oe_o = cycle_end_q & irq_en_q;
  assign irq_n_o  = 1'b0;

  // read data
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `EPLA_LINE_RESULT_ADR: rdata_q <= {8'h00, line_result_q};
        `EPLA_OFFSET_ADR:      rdata_q <= {16'h0000, offset_q};
        `EPLA_NUMER_ADR:       rdata_q <= {20'h00000, numer_q};
        `EPLA_DIVIS_ADR:       rdata_q <= {20'h00000, divis_q};
        `EPLA_MODE_ADR:        rdata_q <= {24'h000000, mode_q};
        `EPLA_STATUS_ADR:      rdata_q <= {29'h00000000, cycle_end_q, 2'h0};
        `EPLA_HALF_COUNT_ADR:  rdata_q <= {16'h0000, half_count_q};
        `EPLA_IRQ_EN_ADR:      rdata_q <= {29'h00000000, irq_en_q, 2'h0};
        `EPLA_ENERGY_ADR:      rdata_q <= {8'h00, energy};
        default:               rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // assertions
  ack_single_cycle_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  tick_spacing_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    tick |=> !tick [*3] ##1 tick)
    else $error("sample tick not every four clocks");

  energy_accumulate_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    tick |=> acc_q == $past(acc_q) + $past(corr))
    else $error("energy accumulator missed corrected sample");

  dfc_on_change_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $changed(energy) |=> dfc_q)
    else $error("converter pulse missing after energy LSB change");

  ratio_clamp_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (dfc_q && num_eff >= den_eff) |=> emit_q ##1 calibration_pulse_out_o)
    else $error("clamped ratio did not emit on every converter pulse");

  fixed_width_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (emit_q && numer_q == 12'h001 && divis_q == 12'h001)
      |=> width_q == 24'(FIXED_CYCLES))
    else $error("fixed pulse width not 64 clocks");

  hold_width_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (emit_q && !fixed_width && {8'h00, period_q} > LONG_CYCLES)
      |=> width_q == 24'(HOLD_CYCLES))
    else $error("long period pulse width not hold time");

  half_duty_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (emit_q && !fixed_width && {8'h00, period_q} <= LONG_CYCLES && period_q > 24'h000003)
      |=> width_q == {1'b0, $past(period_q[23:1])})
    else $error("pulse width not half of period");

  cycle_end_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    complete |=> cycle_end_q && line_result_q == $past(line_next[56:33]))
    else $error("completion did not set flag and load result");

  irq_drive_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (complete && irq_en_q) |=> irq_oe_o && !irq_n_o)
    else $error("enabled cycle end did not drive interrupt low");

  line_restart_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (complete && line_mode) |=> state_q == EPLA_ACCUM && half_cnt_q == 16'h0000)
    else $error("line accumulation did not restart");

  mode_exit_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !line_mode |=> state_q == EPLA_IDLE)
    else $error("line state active with mode bit clear");

endmodule

// >>> tb/epla_cal_counter.sv
`timescale 1ns/1ps
// counts calibration pulses and times how long the last one stayed high
module epla_cal_counter (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        pulse_i,
  output logic      [31:0] count_o,
  output logic      [31:0] width_o
);
  logic        last_q;
  logic [31:0] run_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_q  <= 1'b0;
      run_q   <= '0;
      count_o <= '0;
      width_o <= '0;
    end else begin
      last_q <= pulse_i;
      if (pulse_i && !last_q)
        count_o <= count_o + 32'h1;
      if (pulse_i)
        run_q <= run_q + 32'h1;
      else
        run_q <= '0;
      if (!pulse_i && last_q)
        width_o <= run_q;
    end
  end
endmodule

// >>> tb/tb_energy_pulse_and_line_cycle_accum.sv
`timescale 1ns/1ps
`include "epla_cfg.svh"
module tb_energy_pulse_and_line_cycle_accum;
  logic        clock_i  = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, zc = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic [23:0] smp = 24'h00_0000;
  logic [31:0] rdat, q, cnt, wid, c0, wv;
  logic [56:0] a0;
  logic [23:0] e0, dif;
  logic        ack, cal, irq_n, irq_oe;
  int          bad_count = 0, n_checks = 0, cycles = 0, st, es, nn, dd, per;
  longint      t0, t;
  logic [31:0] rng = 32'h581527C2;
  int tn[4] = '{0, 1, 0, 3};
  int td[4] = '{0, 1, 3, 0};
  int ts[4] = '{65536, 65536, 524288, 524288};
  int tc[4] = '{10240, 10240, 5120, 5120};
  logic [7:0]  ra[4] = '{8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [31:0] rm[4] = '{32'h0000_FFFF, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0000_FFFF};
  logic [7:0]  za[10] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h40};

  // small long-count parameters keep the hold and long-period cases reachable
  epla_energy_pulse #(.HOLD_CYCLES(200), .LONG_CYCLES(400)) epla_energy_pulse_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .power_sample_i(smp), .zero_cross_i(zc), .calibration_pulse_out_o(cal),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe));

  epla_cal_counter epla_cal_counter_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .pulse_i(cal), .count_o(cnt), .width_o(wid));

  initial forever #10 clock_i = ~clock_i;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic int exp_w(int num, int div, int p);
    if (num == 1 && div == 1)
      return 64;
    if (p > 400)
      return 200;
    return p / 2;
  endfunction

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // waits for ack as long as it takes; only the run timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n < 20, "slow ack");
  endtask

  task automatic zpulse();
    @(posedge clock_i);
    zc <= 1'b1;
    @(posedge clock_i);
    zc <= 1'b0;
  endtask

  task automatic lperiod(input int gap, input logic irq_exp);
    repeat (2) begin
      repeat (gap) @(posedge clock_i);
      zpulse();
    end
    xfer(1'b0, `EPLA_STATUS_ADR, 32'h0);
    chk(q[2] === 1'b0, "flag early");
    repeat (gap) @(posedge clock_i);
    zpulse();
    t = ($time - t0) / 20;
    t0 = $time;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk(irq_oe === irq_exp && irq_n === 1'b0, "irq pin");
    xfer(1'b0, `EPLA_STATUS_ADR, 32'h0);
    chk(q[2] === 1'b1, "no cycle end flag");
    xfer(1'b0, `EPLA_LINE_RESULT_ADR, 32'h0);
    es = int'(((t / 4) * 64'd8388607) >>> 25);
    st = int'(q[23:0]);
    chk(st >= es - 1 && st <= es + 1, "line energy");
    $display("line period of %0d clocks done", t);
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (za[i]) begin
      xfer(1'b0, za[i], 32'h0);
      chk(q === 32'h0, "reset value");
    end
    foreach (ra[i]) begin
      wv = xs();
      xfer(1'b1, ra[i], wv);
      xfer(1'b0, ra[i], 32'h0);
      chk(q === (wv & rm[i]), "readback");
      xfer(1'b1, ra[i], 32'h0);
    end
    xfer(1'b1, `EPLA_LINE_RESULT_ADR, xs());
    xfer(1'b1, 8'h40, xs());
    xfer(1'b0, `EPLA_LINE_RESULT_ADR, 32'h0);
    chk(q === 32'h0, "read-only written");
    xfer(1'b0, 8'h40, 32'h0);
    chk(q === 32'h0, "unmapped read");
    $display("register test done");
    foreach (tn[i]) begin
      xfer(1'b1, `EPLA_NUMER_ADR, tn[i]);
      xfer(1'b1, `EPLA_DIVIS_ADR, td[i]);
      xfer(1'b0, `EPLA_ENERGY_ADR, 32'h0);
      e0 = q[23:0];
      c0 = cnt;
      @(posedge clock_i);
      smp <= ts[i][23:0];
      repeat (tc[i]) @(posedge clock_i);
      smp <= 24'h00_0000;
      repeat (10) @(posedge clock_i);
      xfer(1'b0, `EPLA_ENERGY_ADR, 32'h0);
      dif = q[23:0] - e0;
      st = $signed(dif);
      es = (tc[i] / 4 * ts[i]) >>> 25;
      chk(st >= es - 1 && st <= es + 1, "energy steps");
      nn = (tn[i] == 0 ? 1 : tn[i]) + 1;
      dd = (td[i] == 0 ? 1 : td[i]) + 1;
      nn = nn > dd ? dd : nn;
      es = st * nn / dd;
      st = int'(cnt - c0);
      chk(st >= es - 1 && st <= es + 1, "pulse count");
      per = 134217728 / ts[i] * dd / nn;
      st = int'(wid) - exp_w(tn[i], td[i], per);
      chk(st >= -1 && st <= 1, "pulse width");
      $display("pulse case %0d done", i);
    end
    @(posedge clock_i);
    smp <= 24'h00_0080;
    xfer(1'b1, `EPLA_OFFSET_ADR, 32'h0000_8000);
    xfer(1'b0, `EPLA_ENERGY_ADR, 32'h0);
    e0 = q[23:0];
    c0 = cnt;
    a0 = epla_energy_pulse_inst.acc_q;
    repeat (2000) @(posedge clock_i);
    xfer(1'b0, `EPLA_ENERGY_ADR, 32'h0);
    chk(q[23:0] === e0 && cnt === c0, "offset cancel");
    chk(epla_energy_pulse_inst.acc_q === a0, "offset not applied at 1/256 scale");
    xfer(1'b1, `EPLA_OFFSET_ADR, 32'h0);
    $display("offset test done");
    xfer(1'b1, `EPLA_HALF_COUNT_ADR, 32'h3);
    xfer(1'b1, `EPLA_MODE_ADR, 32'h80);
    smp <= 24'h7F_FFFF;
    zpulse();
    t0 = $time;
    lperiod(800, 1'b0);
    xfer(1'b1, `EPLA_STATUS_ADR, 32'h4);
    xfer(1'b1, `EPLA_IRQ_EN_ADR, 32'h4);
    lperiod(400, 1'b1);
    xfer(1'b1, `EPLA_STATUS_ADR, 32'h4);
    @(negedge clock_i);
    chk(irq_oe === 1'b0, "irq not released");
    xfer(1'b1, `EPLA_MODE_ADR, 32'h0);
    repeat (4) begin
      repeat (100) @(posedge clock_i);
      zpulse();
    end
    xfer(1'b0, `EPLA_STATUS_ADR, 32'h0);
    chk(q[2] === 1'b0, "completion with mode off");
    $display("line cycle test done");
    complete_run();
  end
endmodule
